// ===== pvas_pkg.sv
// Shared constants and types for process value alarm scaling
package pvas_pkg;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS     = 100;
   localparam int unsigned ALARM_TICK_NS     = 1000000;
   localparam int unsigned ALARM_TICK_CYCLES = ALARM_TICK_NS / CLK_PERIOD_NS;

   // ----------------------------------------------------------------
   // Levels in 0.01 % of input span
   // ----------------------------------------------------------------
   localparam logic [13:0] FULL_SCALE     = 14'h2710; // 100.00 %
   localparam logic [13:0] SQRT_ON_LEVEL  = 14'h0032; // 0.50 %
   localparam logic [13:0] SQRT_OFF_LEVEL = 14'h001e; // 0.30 %
   localparam logic [13:0] INRUSH_LEVEL   = 14'h00c8; // 2.00 %
   localparam int unsigned ROOT_W         = 14;
   localparam logic signed [33:0] GAIN_UNIT = 34'sh0000_2710; // 1/0.0001

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_RMIN   = 8'h04;
   localparam logic [7:0] ADDR_RMAX   = 8'h08;
   localparam logic [7:0] ADDR_GAIN   = 8'h0c;
   localparam logic [7:0] ADDR_ZERO   = 8'h10;
   localparam logic [7:0] ADDR_HYST   = 8'h14;
   localparam logic [7:0] ADDR_DELAY  = 8'h18;
   localparam logic [7:0] ADDR_SETHH  = 8'h1c;
   localparam logic [7:0] ADDR_SETH   = 8'h20;
   localparam logic [7:0] ADDR_SETL   = 8'h24;
   localparam logic [7:0] ADDR_SETLL  = 8'h28;
   localparam logic [7:0] ADDR_INRUSH = 8'h2c;
   localparam logic [7:0] ADDR_STATUS = 8'h30;
   localparam logic [7:0] ADDR_PV     = 8'h34;

   // ----------------------------------------------------------------
   // Field positions and alarm indices
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_SQRT_BIT   = 0;
   localparam int unsigned CTRL_DIR_BIT    = 1; // 1: overrange high
   localparam int unsigned CTRL_INRUSH_BIT = 2;
   localparam int unsigned ALM_HH = 0;
   localparam int unsigned ALM_H  = 1;
   localparam int unsigned ALM_L  = 2;
   localparam int unsigned ALM_LL = 3;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [2:0]  CTRL_RST   = 3'h0;
   localparam logic [15:0] RMIN_RST   = 16'h0000;
   localparam logic [15:0] RMAX_RST   = 16'h0fa0;
   localparam logic [15:0] GAIN_RST   = 16'h2710;
   localparam logic [15:0] SETHI_RST  = 16'h0fa0;
   localparam logic [15:0] SETLO_RST  = 16'h0000;
   localparam logic [15:0] INRUSH_RST = 16'h0064;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        open; // input disconnected
      logic [13:0] raw;  // 0.01 % units
   } pvas_sample_type;

   typedef struct packed {
      logic signed [15:0] pv;
      logic [3:0]         alarm;
      logic               sqrt_mode;
      logic               inrush_active;
   } pvas_result_type;

   typedef struct packed {
      logic [2:0]       ctrl;
      logic [15:0]      range_min;
      logic [15:0]      range_max;
      logic [15:0]      gain;
      logic [15:0]      zero;
      logic [15:0]      hyst;
      logic [15:0]      delay;
      logic [3:0][15:0] set;
      logic [15:0]      inrush_time;
   } pvas_cfg_type;

   localparam pvas_cfg_type CFG_RST = '{
      ctrl: CTRL_RST, range_min: RMIN_RST, range_max: RMAX_RST,
      gain: GAIN_RST, zero: 16'h0000, hyst: 16'h0000, delay: 16'h0000,
      set: {SETLO_RST, SETLO_RST, SETHI_RST, SETHI_RST},
      inrush_time: INRUSH_RST};

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ROOT = 2'b01,
      ST_CALC = 2'b10
   } pvas_state_type;

   typedef struct packed {
      logic        busy;
      logic [3:0]  step;
      logic [27:0] rad;
      logic [16:0] rem;
      logic [13:0] root;
      logic        done;
   } pvas_sqrt_state_type;

endpackage

// ===== pvas_sqrt.sv
// Sequential integer square root, one result bit per clock
module pvas_sqrt (
   input  wire logic                    pclk,     // Bus clock
   input  wire logic                    presetn,  // Async reset, low
   input  wire logic                    start,    // Start pulse
   input  wire logic [2*pvas_pkg::ROOT_W-1:0] radicand, // Operand
   output logic                         done,     // Result pulse
   output logic [pvas_pkg::ROOT_W-1:0]  root      // Floor square root
);
   import pvas_pkg::*;

   pvas_sqrt_state_type s;
   pvas_sqrt_state_type next_s;

   // ----------------------------------------------------------------
   // Restoring root extraction
   // ----------------------------------------------------------------
   // Two radicand bits per step keeps the datapath to one subtractor
   always_comb
   begin
      logic [16:0] rem_sh;
      logic [16:0] trial;
      next_s      = s;
      next_s.done = 1'b0;
      rem_sh      = {s.rem[14:0], s.rad[27:26]};
      trial       = {1'b0, s.root, 2'b01};
      if (!s.busy)
      begin
         if (start)
         begin
            next_s.busy = 1'b1;
            next_s.step = 4'h0;
            next_s.rad  = radicand;
            next_s.rem  = 17'h00000;
            next_s.root = 14'h0000;
         end
      end
      else
      begin
         next_s.rad = {s.rad[25:0], 2'b00};
         if (rem_sh >= trial)
         begin
            next_s.rem  = rem_sh - trial;
            next_s.root = {s.root[12:0], 1'b1};
         end
         else
         begin
            next_s.rem  = rem_sh;
            next_s.root = {s.root[12:0], 1'b0};
         end
         next_s.step = s.step + 4'h1;
         if (s.step == 4'(ROOT_W - 1))
         begin
            next_s.busy = 1'b0;
            next_s.done = 1'b1;
         end
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= '0;
      else
         s <= next_s;
   end

   assign done = s.done;
   assign root = s.root;

   // Fixed latency from start to result
   AST_SQRT_LATENCY: assert property (@(posedge pclk) disable iff (!presetn)
      (start && !s.busy) |-> ##15 done)
      else $error("square root result late or early");

endmodule // pvas_sqrt

// ===== pvas_core.sv
// Process value scaling, square root, inrush and alarm core with APB
// How it works
// - Alarm stays off if condition clears before on-delay elapses.
// - Range maximum below minimum gives falling value for rising input.
// - Alarms compare the scaled process value, never the raw input.
// - High-high and high alarms on when value exceeds set value.
// - Low-low and low alarms on when value is below set value.
// - Disconnected input with high overrange forces range maximum.
// - Disconnected input with low overrange forces range minimum.
// - Inrush limit stays off if value exceeds 2% at startup.
// - Inrush limit engages only on first upward crossing of 2%.
// - Square root mode uses output equals input near the bottom.
// - Rising input switches to square root at 0.5%.
// - Falling input returns to linear at 0.3%.
// - Value is (in - min) times gain/10000 plus min plus zero.
module pvas_core #(
   parameter int unsigned TICK_CYCLES = pvas_pkg::ALARM_TICK_CYCLES
) (
   input  wire logic        pclk,         // Bus clock, 10 MHz
   input  wire logic        presetn,      // Async reset, low
   input  wire logic        psel,         // APB select
   input  wire logic        penable,      // APB enable
   input  wire logic        pwrite,       // APB direction
   input  wire logic [7:0]  paddr,        // APB byte address
   input  wire logic [31:0] pwdata,       // APB write data
   output logic [31:0]      prdata,       // APB read data
   output logic             pready,       // APB ready
   output logic             pslverr,      // APB error
   input  wire logic        sample_valid, // New converter sample
   input  wire pvas_pkg::pvas_sample_type sample, // Sample word
   output logic             sample_ready, // Core can take a sample
   output logic             pv_valid,     // New process value pulse
   output pvas_pkg::pvas_result_type result // Value and flags
);
   import pvas_pkg::*;

   typedef struct packed {
      pvas_state_type   st;
      logic [13:0]      raw;
      logic             open;
      logic [13:0]      lin;
      logic [15:0]      pv;
      logic             pv_valid;
      logic             sqrt_mode;
      logic             first_done;
      logic             armed;
      logic             prev_low;
      logic [15:0]      inr_cnt;
      logic [3:0]       alarm;
      logic [3:0][15:0] dcnt;
      logic [15:0]      tick_cnt;
      logic             tick;
      pvas_cfg_type     cfg;
      logic [31:0]      prdata;
      logic             pslverr;
   } pvas_core_state_type;

   localparam pvas_core_state_type STATE_RST = '{st: ST_IDLE, cfg: CFG_RST,
                                                  default: '0};

   pvas_core_state_type s;
   pvas_core_state_type next_s;
   logic [3:0]          cond;
   logic                sqrt_start;
   logic                sqrt_done;
   logic [13:0]         sqrt_root;
   logic                inr_active;

   // ----------------------------------------------------------------
   // Arithmetic helpers
   // ----------------------------------------------------------------
   // Product scaled by 0.0001; range fits 34 bits for 16-bit operands
   function automatic logic signed [31:0] mul_div(
      input logic signed [16:0] a,
      input logic signed [16:0] b);
      logic signed [33:0] p;
      p       = a * b;
      mul_div = 32'(p / GAIN_UNIT);
   endfunction

   // Clip to the signed 16-bit process value range
   function automatic logic [15:0] sat16(input logic signed [31:0] v);
      if (v > 32'sd32767)
         sat16 = 16'h7fff;
      else if (v < -32'sd32768)
         sat16 = 16'h8000;
      else
         sat16 = v[15:0];
   endfunction

   // Alarm condition; an alarm already on holds across the hysteresis
   function automatic logic alarm_cond(
      input logic        on,
      input logic        high,
      input logic [15:0] pv,
      input logic [15:0] sv,
      input logic [15:0] hy);
      logic signed [16:0] p;
      logic signed [16:0] t;
      p = 17'($signed(pv));
      t = 17'($signed(sv));
      if (high)
         alarm_cond = on ? (p >= t - 17'($signed(hy))) : (p > t);
      else
         alarm_cond = on ? (p <= t + 17'($signed(hy))) : (p < t);
   endfunction

   // ----------------------------------------------------------------
   // Alarm conditions
   // ----------------------------------------------------------------
   assign inr_active = (s.inr_cnt != 16'h0000);

   // Alarms see the scaled value; inrush masks them while it runs
   always_comb
   begin
      for (int k = 0; k < 4; k++)
      begin
         cond[k] = !inr_active && alarm_cond(s.alarm[k], (k < 2),
                   s.pv, s.cfg.set[k], s.cfg.hyst);
      end
   end

   assign sqrt_start = sample_valid && (s.st == ST_IDLE) && !sample.open
                       && s.cfg.ctrl[CTRL_SQRT_BIT]
                       && (s.sqrt_mode ? (sample.raw > SQRT_OFF_LEVEL)
                                       : (sample.raw >= SQRT_ON_LEVEL));

   pvas_sqrt u_sqrt (
      .pclk     (pclk),
      .presetn  (presetn),
      .start    (sqrt_start),
      .radicand (28'(sample.raw * 28'h0002710)),
      .done     (sqrt_done),
      .root     (sqrt_root)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb
   begin
      logic signed [16:0] diff;
      logic [15:0]        scaled;
      logic [15:0]        adj;
      next_s          = s;
      next_s.pv_valid = 1'b0;
      diff   = 17'($signed(s.cfg.range_max)) - 17'($signed(s.cfg.range_min));
      scaled = sat16(mul_div(diff, {3'b000, s.lin})
                     + 32'($signed(s.cfg.range_min)));
      adj    = sat16(mul_div(17'($signed(scaled))
                     - 17'($signed(s.cfg.range_min)), {1'b0, s.cfg.gain})
                     + 32'($signed(s.cfg.range_min))
                     + 32'($signed(s.cfg.zero)));

      // Sample path; samples offered while busy are not taken
      case (s.st)
         ST_IDLE:
         begin
            if (sample_valid)
            begin
               next_s.raw  = sample.raw;
               next_s.open = sample.open;
               next_s.lin  = sample.raw;
               if (!sample.open)
               begin
                  if (!s.sqrt_mode && sample.raw >= SQRT_ON_LEVEL)
                     next_s.sqrt_mode = 1'b1;
                  if (s.sqrt_mode && sample.raw <= SQRT_OFF_LEVEL)
                     next_s.sqrt_mode = 1'b0;
               end
               next_s.st = sqrt_start ? ST_ROOT : ST_CALC;
            end
         end
         ST_ROOT:
         begin
            if (sqrt_done)
            begin
               next_s.lin = sqrt_root;
               next_s.st  = ST_CALC;
            end
         end
         ST_CALC:
         begin
            next_s.pv_valid = 1'b1;
            next_s.st       = ST_IDLE;
            next_s.pv       = adj;
            if (s.open)
            begin
               next_s.pv = s.cfg.ctrl[CTRL_DIR_BIT] ? s.cfg.range_max
                                                    : s.cfg.range_min;
            end
            if (inr_active)
               next_s.inr_cnt = s.inr_cnt - 16'h0001;
            if (!s.open)
            begin
               next_s.prev_low = (s.lin <= INRUSH_LEVEL);
               if (!s.first_done)
               begin
                  next_s.first_done = 1'b1;
                  next_s.armed      = (s.lin <= INRUSH_LEVEL);
               end
               else if (s.armed && s.prev_low && s.lin > INRUSH_LEVEL)
               begin
                  next_s.armed = 1'b0;
                  if (s.cfg.ctrl[CTRL_INRUSH_BIT])
                     next_s.inr_cnt = s.cfg.inrush_time;
               end
            end
         end
         default:
            next_s.st = ST_IDLE;
      endcase

      // Millisecond tick for the on-delay
      next_s.tick     = 1'b0;
      next_s.tick_cnt = s.tick_cnt + 16'h0001;
      if (s.tick_cnt == 16'(TICK_CYCLES - 1))
      begin
         next_s.tick     = 1'b1;
         next_s.tick_cnt = 16'h0000;
      end

      for (int k = 0; k < 4; k++)
      begin
         if (!cond[k])
         begin
            next_s.alarm[k] = 1'b0;
            next_s.dcnt[k]  = 16'h0000;
         end
         else if (!s.alarm[k])
         begin
            // all four alarms set on delay expiry
            if (s.dcnt[k] >= s.cfg.delay)
               next_s.alarm[k] = 1'b1;
            else if (s.tick)
               next_s.dcnt[k] = s.dcnt[k] + 16'h0001;
         end
      end

      // APB: read data latched in setup, write taken in access
      if (psel && !penable)
      begin
         next_s.pslverr = 1'b0;
         case (paddr)
            ADDR_CTRL:   next_s.prdata = {29'h0, s.cfg.ctrl};
            ADDR_RMIN:   next_s.prdata = {16'h0, s.cfg.range_min};
            ADDR_RMAX:   next_s.prdata = {16'h0, s.cfg.range_max};
            ADDR_GAIN:   next_s.prdata = {16'h0, s.cfg.gain};
            ADDR_ZERO:   next_s.prdata = {16'h0, s.cfg.zero};
            ADDR_HYST:   next_s.prdata = {16'h0, s.cfg.hyst};
            ADDR_DELAY:  next_s.prdata = {16'h0, s.cfg.delay};
            ADDR_SETHH:  next_s.prdata = {16'h0, s.cfg.set[ALM_HH]};
            ADDR_SETH:   next_s.prdata = {16'h0, s.cfg.set[ALM_H]};
            ADDR_SETL:   next_s.prdata = {16'h0, s.cfg.set[ALM_L]};
            ADDR_SETLL:  next_s.prdata = {16'h0, s.cfg.set[ALM_LL]};
            ADDR_INRUSH: next_s.prdata = {16'h0, s.cfg.inrush_time};
            ADDR_STATUS: next_s.prdata = {24'h0, s.open, s.armed,
                                          inr_active, s.sqrt_mode, s.alarm};
            ADDR_PV:     next_s.prdata = {16'h0, s.pv};
            default:
            begin
               next_s.prdata  = 32'h0000_0000;
               next_s.pslverr = 1'b1;
            end
         endcase
      end
      if (psel && penable && pwrite)
      begin
         case (paddr)
            ADDR_CTRL:   next_s.cfg.ctrl        = pwdata[2:0];
            ADDR_RMIN:   next_s.cfg.range_min   = pwdata[15:0];
            ADDR_RMAX:   next_s.cfg.range_max   = pwdata[15:0];
            ADDR_GAIN:   next_s.cfg.gain        = pwdata[15:0];
            ADDR_ZERO:   next_s.cfg.zero        = pwdata[15:0];
            ADDR_HYST:   next_s.cfg.hyst        = pwdata[15:0];
            ADDR_DELAY:  next_s.cfg.delay       = pwdata[15:0];
            ADDR_SETHH:  next_s.cfg.set[ALM_HH] = pwdata[15:0];
            ADDR_SETH:   next_s.cfg.set[ALM_H]  = pwdata[15:0];
            ADDR_SETL:   next_s.cfg.set[ALM_L]  = pwdata[15:0];
            ADDR_SETLL:  next_s.cfg.set[ALM_LL] = pwdata[15:0];
            ADDR_INRUSH: next_s.cfg.inrush_time = pwdata[15:0];
            default:     next_s.cfg             = s.cfg;
         endcase
      end
   end

   // State register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         s <= STATE_RST;
      else
         s <= next_s;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign prdata       = s.prdata;
   assign pslverr      = s.pslverr;
   assign pready       = 1'b1; // Zero wait states
   assign sample_ready = (s.st == ST_IDLE);
   assign pv_valid     = s.pv_valid;
   assign result       = '{pv: s.pv, alarm: s.alarm,
                           sqrt_mode: s.sqrt_mode, inrush_active: inr_active};

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic above_h;
   assign above_h = ($signed(s.pv) > $signed(s.cfg.set[ALM_H]));

   sequence s_open_calc(logic dir);
      s.st == ST_CALC && s.open && s.cfg.ctrl[CTRL_DIR_BIT] == dir;
   endsequence

   AST_HOLD_OFF: assert property (
      (!s.alarm[ALM_H] && !cond[ALM_H]) |=> !s.alarm[ALM_H])
      else $error("alarm rose without a standing condition");
   AST_NEG_FULL: assert property (
      (s.st == ST_CALC && !s.open && s.lin == FULL_SCALE
       && s.cfg.gain == GAIN_RST && s.cfg.zero == 16'h0000
       && $signed(s.cfg.range_max) < $signed(s.cfg.range_min))
      |=> s.pv == $past(s.cfg.range_max))
      else $error("full input did not give range maximum");
   AST_PV_BASIS: assert property (
      $rose(s.alarm[ALM_H]) |-> $past(above_h))
      else $error("high alarm rose with value not above set");
   AST_HIGH_ON: assert property (
      (s.cfg.delay == 16'h0000 && !inr_active && !s.alarm[ALM_HH]
       && $signed(s.pv) > $signed(s.cfg.set[ALM_HH])) |=> s.alarm[ALM_HH])
      else $error("high-high alarm missed");
   AST_LOW_ON: assert property (
      (s.cfg.delay == 16'h0000 && !inr_active && !s.alarm[ALM_LL]
       && $signed(s.pv) < $signed(s.cfg.set[ALM_LL])) |=> s.alarm[ALM_LL])
      else $error("low-low alarm missed");
   AST_OPEN_MAX: assert property (
      s_open_calc(1'b1) |=> s.pv == $past(s.cfg.range_max))
      else $error("open input not forced to maximum");
   AST_OPEN_MIN: assert property (
      s_open_calc(1'b0) |=> s.pv == $past(s.cfg.range_min))
      else $error("open input not forced to minimum");
   AST_INRUSH_SKIP: assert property (
      (s.st == ST_CALC && !s.open && !s.first_done
       && s.lin > INRUSH_LEVEL) |=> !s.armed ##1 !s.armed)
      else $error("inrush armed although started above level");
   AST_INRUSH_CROSS: assert property (
      $rose(inr_active) |-> $past(s.prev_low) && $past(s.armed))
      else $error("inrush engaged without upward crossing");
   AST_SQRT_LIN: assert property (
      (s.st == ST_CALC && !s.sqrt_mode) |-> s.lin == s.raw)
      else $error("linear band altered the input");
   AST_SQRT_UP: assert property (
      $rose(s.sqrt_mode) |-> s.raw >= SQRT_ON_LEVEL)
      else $error("root mode entered below on level");
   AST_SQRT_DOWN: assert property (
      $fell(s.sqrt_mode) |-> s.raw <= SQRT_OFF_LEVEL)
      else $error("root mode left above off level");
   AST_TIMER_CLEAR: assert property (
      !cond[ALM_L] |=> s.dcnt[ALM_L] == 16'h0000 && !s.alarm[ALM_L])
      else $error("on-delay timer not restarted");

endmodule // pvas_core

// ===== pvas_cpu_model.sv
// Controller side model that reads back each new process value
module pvas_cpu_model
   import pvas_pkg::*;
(
   input  wire logic             pclk,     // Bus clock
   input  wire logic             pv_valid, // New value pulse
   input  wire pvas_result_type  result,   // Value and flags
   output logic signed [15:0]    last_pv   // Value read back
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge pclk)
      if (pv_valid) last_pv <= result.pv;
endmodule // pvas_cpu_model

// ===== test_process_value_alarm_scaling.sv
// Testbench for the process value alarm scaling core
module test_process_value_alarm_scaling;
   import pvas_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, sample_valid = 0, sample_ready, pv_valid;
   pvas_sample_type    sample = '0;
   pvas_result_type    result;
   logic signed [15:0] last_pv;
   int err_count = 0, num_checks = 0;
   int raw_t[5] = '{20, 40, 50, 40, 30};
   int pv_t[5]  = '{20, 40, 707, 632, 30}; // Root path gives floor
   pvas_core #(.TICK_CYCLES(10)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_valid(sample_valid), .sample(sample),
      .sample_ready(sample_ready), .pv_valid(pv_valid), .result(result));
   pvas_cpu_model cpu (.pclk(pclk), .pv_valid(pv_valid), .result(result),
      .last_pv(last_pv));
   initial forever #50 pclk = ~pclk;
   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   task automatic rst();
      @(posedge pclk) presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
   endtask
   // One APB transfer; the master waits for pready before releasing
   task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk) penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      {psel, penable} <= 2'b00;
   endtask
   // Offer one sample, then wait until the controller model holds it
   task automatic send(logic [13:0] r, logic o = 1'b0);
      @(posedge pclk) {sample_valid, sample} <= {1'b1, o, r};
      @(posedge pclk) sample_valid <= 1'b0;
      // The core stays busy until its result is out
      @(negedge pclk) chk("ready", sample_ready, 0);
      do @(negedge pclk); while (pv_valid !== 1'b1);
      @(negedge pclk);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      #3000000 err_count++;
      report_and_stop();
   end
   initial
   begin
      rst(); xfer(1, ADDR_CTRL, 4); send(300);
      chk("inrush", result.inrush_active, 0);
      rst(); xfer(1, ADDR_CTRL, 4); send(100); send(300);
      chk("inrush", result.inrush_active, 1);
      $display("test inrush done");
      rst(); xfer(0, ADDR_GAIN, 0); chk("gain", rd, 32'(GAIN_RST));
      xfer(0, 8'hfc, 0); chk("slverr", pslverr, 1);
      $display("test registers done");
      xfer(1, ADDR_GAIN, 10060); xfer(1, ADDR_ZERO, 5); send(1250);
      chk("pv", 32'(last_pv), 500 * 10060 / 10000 + 5);
      xfer(0, ADDR_PV, 0); chk("pv_reg", rd, 508);
      xfer(1, ADDR_GAIN, 10000); xfer(1, ADDR_ZERO, 7); send(0);
      chk("pv", 32'(last_pv), 7);
      xfer(1, ADDR_ZERO, 0); send(0); chk("pv", 32'(last_pv), 0);
      xfer(1, ADDR_GAIN, 9990); send(10000);
      chk("pv", 32'(last_pv), 3996);
      xfer(1, ADDR_GAIN, 10000); send(10000);
      chk("pv", 32'(last_pv), 4000);
      $display("test scaling done");
      xfer(1, ADDR_RMIN, 4000); xfer(1, ADDR_RMAX, 0);
      xfer(1, ADDR_SETL, 3500); xfer(1, ADDR_SETLL, 3100);
      send(2500); chk("pv", 32'(last_pv), 3000);
      // High set values land after the value settles, so none hold stale
      xfer(1, ADDR_SETH, 3000); xfer(1, ADDR_SETHH, 3100);
      repeat (2) @(negedge pclk); chk("alarm", result.alarm, 4'hc);
      send(2000); chk("pv", 32'(last_pv), 3200);
      repeat (2) @(negedge pclk); chk("alarm", result.alarm, 4'h7);
      send(10000); chk("pv", 32'(last_pv), 0);
      for (int d = 0; d < 2; d++)
      begin
         xfer(1, ADDR_CTRL, d * 2); send(0, 1'b1);
         chk("open", 32'(last_pv), d ? 0 : 4000);
      end
      $display("test negative bias done");
      xfer(1, ADDR_DELAY, 3); send(2000); repeat (10) @(negedge pclk);
      send(2500); repeat (40) @(negedge pclk);
      chk("alarm_h", result.alarm[ALM_H], 0);
      send(2000); repeat (20) @(negedge pclk);
      chk("alarm_h", result.alarm[ALM_H], 0);
      repeat (30) @(negedge pclk); chk("alarm_h", result.alarm[ALM_H], 1);
      $display("test on-delay done");
      xfer(1, ADDR_DELAY, 0); xfer(1, ADDR_RMIN, 0);
      xfer(1, ADDR_RMAX, 10000); xfer(1, ADDR_CTRL, 1);
      foreach (raw_t[i])
      begin
         send(raw_t[i]); chk("root", 32'(last_pv), pv_t[i]);
         chk("mode", result.sqrt_mode, i inside {2, 3});
      end
      $display("test square root done");
      report_and_stop();
   end
endmodule // test_process_value_alarm_scaling
